// ---- design/usc_control.sv ----
// Purpose: Control and status logic of a full/low-speed USB serial engine
// Assumes: SE0 arrives from the transceiver as an asynchronous level
// Notes: Registers reached over Avalon-MM with one wait state per access
module usc_control (
	input wire logic ref_clk,
	input wire logic rst,
	input wire usc_pkg::usc_bus_req_s avs_req,
	output usc_pkg::usc_bus_rsp_s avs_rsp,
	input wire logic bus_se0,
	input wire logic setup_token,
	output usc_pkg::usc_ctrl_s ctrl,
	output logic irq
);
	import usc_pkg::*;

	// ==========================================================
	// State
	typedef enum logic [1:0] {
		USC_BUS_IDLE,
		USC_BUS_ANSWER
	} usc_bus_e;

	typedef struct packed {
		usc_bus_e bus;
		logic [31:0] readdata;
		logic waitrequest;
		logic pp_reset;
		logic pkt_dis;
		logic enable;
		logic resume;
		logic suspend;
		logic [3:0] config_bits;
		logic se0_prev;
		usc_ctrl_s ctrl;
	} usc_state_s;

	usc_state_s state;
	usc_state_s next_state;

	logic se0_sync;
	logic [USC_IRQ_WIDTH-1:0] irq_event;
	logic [USC_IRQ_WIDTH-1:0] irq_status;
	logic [USC_IRQ_WIDTH-1:0] irq_mask;
	logic irq_clear_we;
	logic irq_mask_we;
	logic wr_hit;
	logic [7:0] control_view;

	// ==========================================================
	// Live SE0 flag
	usc_sync u_se0_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in(bus_se0),
		.sync_out(se0_sync)
	);

	// ==========================================================
	// Interrupts
	always_comb begin
		irq_event = '0;
		irq_event[USC_IRQ_SETUP] = setup_token & state.enable & ~state.suspend;
		irq_event[USC_IRQ_SE0_RISE] = se0_sync & ~state.se0_prev & state.enable;
		irq_event[USC_IRQ_SE0_FALL] = ~se0_sync & state.se0_prev & state.enable;
	end

	// Writes commit on the edge at which the master sees waitrequest low
	assign wr_hit = avs_req.write & (state.bus == USC_BUS_ANSWER) & avs_req.byteenable[0];
	assign irq_clear_we = wr_hit & (avs_req.address == USC_OFF_IRQ_STATUS);
	assign irq_mask_we = wr_hit & (avs_req.address == USC_OFF_IRQ_MASK);

	usc_irq #(
		.WIDTH(USC_IRQ_WIDTH)
	) u_irq (
		.ref_clk(ref_clk),
		.rst(rst),
		.event_pulse(irq_event),
		.clear_we(irq_clear_we),
		.clear_bits(avs_req.writedata[USC_IRQ_WIDTH-1:0]),
		.mask_we(irq_mask_we),
		.mask_bits(avs_req.writedata[USC_IRQ_WIDTH-1:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq)
	);

	// ==========================================================
	// Read view of the control register
	always_comb begin
		control_view = '0;
		control_view[USC_BIT_PP_RESET] = state.pp_reset;
		control_view[USC_BIT_SE0] = se0_sync;
		control_view[USC_BIT_PKT_DIS] = state.pkt_dis;
		control_view[USC_BIT_ENABLE] = state.enable;
		control_view[USC_BIT_RESUME] = state.resume;
		control_view[USC_BIT_SUSPEND] = state.suspend;
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_state = state;
		next_state.se0_prev = se0_sync;
		next_state.waitrequest = 1'b1;

		case (state.bus)
			USC_BUS_IDLE: begin
				if (avs_req.read) begin
					next_state.bus = USC_BUS_ANSWER;
					next_state.waitrequest = 1'b0;
					case (avs_req.address)
						USC_OFF_CONTROL: next_state.readdata = {24'h000000, control_view};
						USC_OFF_CONFIG: next_state.readdata = {28'h0000000, state.config_bits};
						USC_OFF_IRQ_STATUS: next_state.readdata = {29'h00000000, irq_status};
						USC_OFF_IRQ_MASK: next_state.readdata = {29'h00000000, irq_mask};
						default: next_state.readdata = 32'h00000000;
					endcase
				end else if (avs_req.write) begin
					next_state.bus = USC_BUS_ANSWER;
					next_state.waitrequest = 1'b0;
				end
			end
			USC_BUS_ANSWER: begin
				// Write lands on the answer edge, so a stalled master never commits early
				next_state.bus = USC_BUS_IDLE;
				next_state.readdata = 32'h00000000;
				if (avs_req.write) begin
					if (avs_req.byteenable[0] && avs_req.address == USC_OFF_CONTROL) begin
						// SE0 bit is never stored from a write
						next_state.pp_reset = avs_req.writedata[USC_BIT_PP_RESET];
						next_state.enable = avs_req.writedata[USC_BIT_ENABLE];
						next_state.resume = avs_req.writedata[USC_BIT_RESUME];
						next_state.suspend = avs_req.writedata[USC_BIT_SUSPEND];
						if (!avs_req.writedata[USC_BIT_PKT_DIS]) begin
							next_state.pkt_dis = 1'b0;
						end
					end
					if (avs_req.byteenable[0] && avs_req.address == USC_OFF_CONFIG) begin
						next_state.config_bits = avs_req.writedata[3:0];
					end
				end
			end
			default: begin
				next_state.bus = USC_BUS_IDLE;
			end
		endcase

		// Set wins over a software clear in the same cycle
		if (setup_token && state.enable && !state.suspend) begin
			next_state.pkt_dis = 1'b1;
		end

		// Engine outputs; held off while disabled, except xcvr_idle (held on), full_speed and ext_xcvr
		next_state.ctrl.engine_on = next_state.enable;
		next_state.ctrl.attached = next_state.enable;
		next_state.ctrl.pkt_enable = next_state.enable & ~next_state.pkt_dis;
		next_state.ctrl.resume_drive = next_state.enable & next_state.resume
			& ~next_state.suspend;
		next_state.ctrl.xcvr_idle = ~next_state.enable | next_state.suspend;
		next_state.ctrl.engine_clk_en = next_state.enable & ~next_state.suspend;
		next_state.ctrl.low_power = next_state.enable & next_state.suspend;
		next_state.ctrl.regulator_on = next_state.enable
			& next_state.config_bits[USC_BIT_REG_SELECT];
		next_state.ctrl.pp_force_even = next_state.enable & next_state.pp_reset
			& next_state.config_bits[USC_BIT_PINGPONG];
		next_state.ctrl.pp_clear = next_state.enable & ~state.enable;
		next_state.ctrl.full_speed = next_state.config_bits[USC_BIT_FULL_SPEED];
		next_state.ctrl.ext_xcvr = next_state.config_bits[USC_BIT_EXT_XCVR];
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= '0;
			state.bus <= USC_BUS_IDLE;
			state.waitrequest <= 1'b1;
			state.config_bits <= USC_CONFIG_RESET;
			state.ctrl.xcvr_idle <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	assign avs_rsp.readdata = state.readdata;
	assign avs_rsp.waitrequest = state.waitrequest;
	assign ctrl = state.ctrl;
endmodule : usc_control

// ---- design/usc_irq.sv ----
// Purpose: Sticky interrupt status with mask and level output
// Assumes: Write-one-to-clear on status
// Notes: A new event in the clearing cycle stays set
module usc_irq #(
	parameter int WIDTH = 3
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] event_pulse,
	input wire logic clear_we,
	input wire logic [WIDTH-1:0] clear_bits,
	input wire logic mask_we,
	input wire logic [WIDTH-1:0] mask_bits,
	output logic [WIDTH-1:0] status,
	output logic [WIDTH-1:0] mask,
	output logic irq
);
	import usc_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] status;
		logic [WIDTH-1:0] mask;
		logic irq;
	} usc_irq_s;

	usc_irq_s state;
	usc_irq_s next_state;

	always_comb begin
		next_state = state;
		if (clear_we) begin
			next_state.status = state.status & ~clear_bits;
		end
		next_state.status = next_state.status | event_pulse;
		if (mask_we) begin
			next_state.mask = mask_bits;
		end
		next_state.irq = |(next_state.status & next_state.mask);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign status = state.status;
	assign mask = state.mask;
	assign irq = state.irq;
endmodule : usc_irq

// ---- design/usc_pkg.sv ----
// Purpose: Shared constants and carriers for the USB engine control block
// Assumes: Avalon-MM register bus, 32-bit data, byte addresses
// Notes: Control register holds the documented bit layout in its low byte
package usc_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] USC_OFF_CONTROL = 4'h0;
	localparam logic [3:0] USC_OFF_CONFIG = 4'h4;
	localparam logic [3:0] USC_OFF_IRQ_STATUS = 4'h8;
	localparam logic [3:0] USC_OFF_IRQ_MASK = 4'hC;

	// ==========================================================
	// Control register fields
	localparam int USC_BIT_PP_RESET = 6;
	localparam int USC_BIT_SE0 = 5;
	localparam int USC_BIT_PKT_DIS = 4;
	localparam int USC_BIT_ENABLE = 3;
	localparam int USC_BIT_RESUME = 2;
	localparam int USC_BIT_SUSPEND = 1;
	localparam logic [7:0] USC_CONTROL_RESET = 8'h00;

	// ==========================================================
	// Configuration register fields
	localparam int USC_BIT_FULL_SPEED = 0;
	localparam int USC_BIT_EXT_XCVR = 1;
	localparam int USC_BIT_REG_SELECT = 2;
	localparam int USC_BIT_PINGPONG = 3;
	localparam logic [3:0] USC_CONFIG_RESET = 4'h0;

	// ==========================================================
	// Interrupt status fields
	localparam int USC_IRQ_SETUP = 0;
	localparam int USC_IRQ_SE0_RISE = 1;
	localparam int USC_IRQ_SE0_FALL = 2;
	localparam int USC_IRQ_WIDTH = 3;
	localparam logic [2:0] USC_IRQ_RESET = 3'h0;

	// ==========================================================
	// Timing
	localparam int USC_CLK_MHZ = 200;
	localparam int USC_PP_CLEAR_CYCLES = 1;

	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} usc_bus_req_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} usc_bus_rsp_s;

	typedef struct packed {
		logic engine_on;
		logic attached;
		logic pkt_enable;
		logic resume_drive;
		logic xcvr_idle;
		logic engine_clk_en;
		logic low_power;
		logic regulator_on;
		logic pp_force_even;
		logic pp_clear;
		logic full_speed;
		logic ext_xcvr;
	} usc_ctrl_s;

endpackage : usc_pkg

// ---- design/usc_sync.sv ----
// Purpose: Three-stage synchroniser for a pin-level input
// Assumes: Input asynchronous to ref_clk
// Notes: A change is accepted once stages two and three agree
module usc_sync (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic async_in,
	output logic sync_out
);
	import usc_pkg::*;

	typedef struct packed {
		logic [2:0] stage;
		logic value;
	} usc_sync_s;

	usc_sync_s state;
	usc_sync_s next_state;

	always_comb begin
		next_state = state;
		next_state.stage = {state.stage[1:0], async_in};
		// Stage 0 is only read by stage 1
		if (state.stage[2] == state.stage[1]) begin
			next_state.value = state.stage[2];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sync_out = state.value;
endmodule : usc_sync

// ---- tb/tb_top.sv ----
// Purpose: Register-level bench for the USB engine control block
// Assumes: One wait state per bus access, as handed over
// Notes: Remote wake-up hold is far shorter than firmware would use
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import usc_pkg::*;
	logic ref_clk, rst, bus_se0, setup_token, irq, se0_req, setup_req;
	usc_bus_req_s req;
	usc_bus_rsp_s rsp;
	usc_ctrl_s ctrl;
	logic [31:0] q;
	int num_errors = 0, checked = 0, pp_seen = 0;
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (ctrl.pp_clear === 1'h1) pp_seen <= pp_seen + 1;
	usc_control dut_u (.ref_clk(ref_clk), .rst(rst), .avs_req(req), .avs_rsp(rsp),
		.bus_se0(bus_se0), .setup_token(setup_token), .ctrl(ctrl), .irq(irq));
	usc_host_model host_u (.ref_clk(ref_clk), .se0_req(se0_req), .setup_req(setup_req),
		.bus_se0(bus_se0), .setup_token(setup_token));
	// ==========================================
	// Tasks
	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Holds the request until waitrequest is seen low at a rising edge
	task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		req <= '{a, !w, w, {24'h0, d}, 4'hF};
		@(posedge ref_clk);
		while (rsp.waitrequest !== 1'h0) begin
			n++;
			if (n > 50) begin
				num_errors++;
				wrap_up();
			end
			@(posedge ref_clk);
		end
		q = rsp.readdata;
		req.read <= 1'h0;
		req.write <= 1'h0;
	endtask : acc
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		acc(a, 1'h1, d);
		repeat (2) @(posedge ref_clk);
	endtask : wr
	task automatic rc(input logic [3:0] a, input logic [31:0] exp);
		acc(a, 1'h0, 8'h0);
		@(posedge ref_clk);
		chk(q, exp);
	endtask : rc
	// ==========================================
	// Sequence
	initial begin
		ref_clk = 1'h0;
		rst = 1'h1;
		req = '0;
		se0_req = 1'h0;
		setup_req = 1'h0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		rc(USC_OFF_CONTROL, 32'h0);
		rc(USC_OFF_CONFIG, 32'h0);
		rc(4'h2, 32'h0);
		chk({ctrl.engine_on, ctrl.xcvr_idle, irq}, 32'h2);
		wr(USC_OFF_CONTROL, 8'hD7);
		chk({ctrl.attached, ctrl.resume_drive, ctrl.low_power, ctrl.pp_force_even}, 32'h0);
		acc(USC_OFF_CONTROL, 1'h0, 8'h0);
		@(posedge ref_clk);
		chk(q & 32'hB1, 32'h0);
		$display("test detached done");
		wr(USC_OFF_CONFIG, 8'h0F);
		rc(USC_OFF_CONFIG, 32'hF);
		wr(USC_OFF_CONTROL, 8'h08);
		chk({ctrl.engine_on, ctrl.attached, ctrl.regulator_on, ctrl.engine_clk_en}, 32'hF);
		chk({ctrl.full_speed, ctrl.ext_xcvr, ctrl.pkt_enable}, 32'h7);
		chk(pp_seen, 32'h1);
		wr(USC_OFF_CONTROL, 8'h48);
		chk(ctrl.pp_force_even, 32'h1);
		wr(USC_OFF_CONFIG, 8'h07);
		chk(ctrl.pp_force_even, 32'h0);
		wr(USC_OFF_CONFIG, 8'h0F);
		rc(USC_OFF_CONTROL, 32'h48);
		wr(USC_OFF_CONTROL, 8'h08);
		$display("test enable done");
		setup_req <= 1'h1;
		repeat (2) @(posedge ref_clk);
		setup_req <= 1'h0;
		repeat (2) @(posedge ref_clk);
		chk(ctrl.pkt_enable, 32'h0);
		rc(USC_OFF_CONTROL, 32'h18);
		rc(USC_OFF_IRQ_STATUS, 32'h1);
		chk(irq, 32'h0);
		wr(USC_OFF_IRQ_MASK, 8'h01);
		chk(irq, 32'h1);
		rc(USC_OFF_IRQ_MASK, 32'h1);
		wr(USC_OFF_CONTROL, 8'h08);
		chk(ctrl.pkt_enable, 32'h1);
		wr(USC_OFF_CONTROL, 8'h18);
		rc(USC_OFF_CONTROL, 32'h08);
		wr(USC_OFF_IRQ_STATUS, 8'h01);
		chk(irq, 32'h0);
		rc(USC_OFF_IRQ_STATUS, 32'h0);
		$display("test setup done");
		wr(USC_OFF_CONTROL, 8'h0C);
		chk(ctrl.resume_drive, 32'h1);
		wr(USC_OFF_CONTROL, 8'h0E);
		chk({ctrl.low_power, ctrl.engine_clk_en, ctrl.xcvr_idle, ctrl.attached}, 32'hB);
		wr(USC_OFF_CONTROL, 8'h08);
		chk({ctrl.low_power, ctrl.engine_clk_en, ctrl.resume_drive}, 32'h2);
		$display("test power done");
		se0_req <= 1'h1;
		repeat (8) @(posedge ref_clk);
		rc(USC_OFF_CONTROL, 32'h28);
		wr(USC_OFF_CONTROL, 8'h08);
		rc(USC_OFF_CONTROL, 32'h28);
		rc(USC_OFF_IRQ_STATUS, 32'h2);
		se0_req <= 1'h0;
		repeat (8) @(posedge ref_clk);
		rc(USC_OFF_CONTROL, 32'h08);
		wr(USC_OFF_CONTROL, 8'h28);
		rc(USC_OFF_CONTROL, 32'h08);
		rc(USC_OFF_IRQ_STATUS, 32'h6);
		wr(USC_OFF_CONTROL, 8'h00);
		chk({ctrl.engine_on, ctrl.attached}, 32'h0);
		$display("test bus state done");
		wrap_up();
	end
endmodule : tb_top

// ---- tb/usc_control_checker.sv ----
// Purpose: Port assertions for the USB engine control block
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to every usc_control instance
module usc_control_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire usc_pkg::usc_bus_req_s avs_req,
	input wire usc_pkg::usc_bus_rsp_s avs_rsp,
	input wire logic bus_se0,
	input wire logic setup_token,
	input wire usc_pkg::usc_ctrl_s ctrl,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	import usc_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ==========================================
	// Bus handshake
	sequence s_taken;
		(avs_req.read || avs_req.write) && avs_rsp.waitrequest;
	endsequence
	sequence s_answer;
		!avs_rsp.waitrequest ##1 avs_rsp.waitrequest;
	endsequence
	a_bus_answer: assert property (s_taken |=> s_answer) else $error("bus answer late");
	a_unimpl_zero: assert property (!avs_rsp.waitrequest && avs_req.read &&
		avs_req.address == USC_OFF_CONTROL |-> avs_rsp.readdata[7] == 1'h0 &&
		avs_rsp.readdata[0] == 1'h0) else $error("unused control bit set");
	// ==========================================
	// Control outputs
	a_detached_idle: assert property (!ctrl.engine_on |-> !ctrl.attached &&
		!ctrl.resume_drive && !ctrl.pp_force_even && !ctrl.regulator_on && !ctrl.low_power)
		else $error("control active while disabled");
	a_enable_clear: assert property ($rose(ctrl.engine_on) |-> ##[0:1] ctrl.pp_clear)
		else $error("no indicator clear on enable");
	a_clear_pulse: assert property (ctrl.pp_clear |=> !ctrl.pp_clear)
		else $error("indicator clear too long");
	a_setup_halt: assert property (setup_token && ctrl.engine_on && !ctrl.low_power
		|=> !ctrl.pkt_enable) else $error("setup did not halt packets");
	a_suspend_idle: assert property (ctrl.low_power |-> !ctrl.engine_clk_en &&
		ctrl.xcvr_idle && ctrl.attached && !ctrl.resume_drive) else $error("suspend state");
	a_regulator_en: assert property (ctrl.regulator_on |-> ctrl.engine_on)
		else $error("regulator on while disabled");
endmodule : usc_control_checker

bind usc_control usc_control_checker chk_u (.ref_clk(ref_clk), .rst(rst), .avs_req(avs_req),
	.avs_rsp(avs_rsp), .bus_se0(bus_se0), .setup_token(setup_token), .ctrl(ctrl), .irq(irq));

// ---- tb/usc_host_model.sv ----
// Purpose: Bus-side partner: single-ended zero level and SETUP token pulses
// Assumes: Commands from the bench change just after a clock edge
// Notes: A token request gives exactly one pulse, however long it is held
module usc_host_model (
	input wire logic ref_clk,
	input wire logic se0_req,
	input wire logic setup_req,
	output logic bus_se0,
	output logic setup_token
);
	timeunit 1ns;
	timeprecision 1ps;
	logic setup_q = 1'h0;
	initial begin
		bus_se0 = 1'h0;
		setup_token = 1'h0;
	end
	always @(posedge ref_clk) begin
		bus_se0 <= se0_req;
		setup_q <= setup_req;
		setup_token <= setup_req && !setup_q;
	end
endmodule : usc_host_model
